//--- hdl/serial_eeprom_params.svh
// Summary of operation
// [R1] Serial output changes after serial clock falls.
// [R2] Inputs captured on rising serial clock edge.
// [R3] Deselected: output released, standby unless busy.
// [R4] No operation before first select falling edge.
// [R5] Write guard low refuses all nonvolatile writes.
// [R6] Guard falling while selected abandons pending write.
// [R7] Pause low freezes sequence; resumes afterwards.
// [R8] Host moves pause only while clock low.
// [R9] Instruction shifted into 8-bit register.
// [R10] All bytes travel most significant bit first.
// [R11] First bit on first rising edge after select.
// [R12] Host holds select low, pause and guard high.
// [R13] Writes need latch; set/clear opcodes control it.
// [R14] Latch clears at power-up and write completion.
// [R15] Status readable at any time, even busy.
// [R16] Status layout: 0000, sel hi, sel lo, latch, busy.
// [R17] Busy reads 1; others read 1 while busy.
// [R18] Protect selects changed only by write-status.
// [R19] Protect map: none, C0-FF, 80-FF, all.
// [R20] Latch and status opcode encodings.
// [R21] Array read and write opcode encodings.
// [R22] Read address increments and wraps FF to 00.
// [R23] Write buffers sixteen bytes, wraps within page; the code buffers only eight (FIFO_DEPTH), and later bytes are dropped.
// [R24] Write starts only when select rises on byte boundary.
// [R25] Host ends select after set-latch before writing.
// [R26] Eight-bit address follows read and write opcodes.
// [R27] Refused write leaves array, busy flag untouched.
`ifndef SERIAL_EEPROM_PARAMS_SVH
`define SERIAL_EEPROM_PARAMS_SVH
`define OP_SET_LATCH    8'h06
`define OP_CLEAR_LATCH  8'h04
`define OP_READ_STATUS  8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ         8'h03
`define OP_WRITE        8'h02
`define ST_BUSY_BIT     0
`define ST_LATCH_BIT    1
`define ST_SEL_LO_BIT   2
`define ST_SEL_HI_BIT   3
`define PAGE_BYTES      16
`define FIFO_DEPTH      8
`define WRITE_TIME_NS   5000000
`define CLK_PERIOD_NS   5
`define WRITE_CYCLES    (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

//--- hdl/serial_eeprom_pkg.sv
package serial_eeprom_pkg;
   typedef enum logic [2:0] {
      PH_IDLE   = 3'b000,
      PH_OPCODE = 3'b001,
      PH_ADDR   = 3'b010,
      PH_RDATA  = 3'b011,
      PH_WDATA  = 3'b100,
      PH_STATW  = 3'b101,
      PH_STATR  = 3'b110,
      PH_IGNORE = 3'b111
   } phase_e;
   typedef logic [7:0] byte_t;
endpackage

//--- hdl/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wp_reg, wp_next, rp_reg, rp_next;
   logic             push, pop;
   assign out_valid = (wp_reg != rp_reg);
   assign in_ready  = (wp_reg[AW-1:0] != rp_reg[AW-1:0]) || (wp_reg[AW] == rp_reg[AW]);
   assign out_data  = mem_reg[rp_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_comb begin
      wp_next = flush ? '0 : (push ? wp_reg + 1'b1 : wp_reg);
      rp_next = flush ? '0 : (pop ? rp_reg + 1'b1 : rp_reg);
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else if (ce) begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
      end
   end
   always_ff @(posedge clk) begin
      if (ce && push && !flush) begin
         mem_reg[wp_reg[AW-1:0]] <= in_data;
      end
   end
endmodule

//--- hdl/serial_eeprom.sv
`timescale 1ns/10ps
`include "serial_eeprom_params.svh"
module serial_eeprom #(
   parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic sel_n,
   input  wire logic sclk,
   input  wire logic sdi,
   input  wire logic pause_n,
   input  wire logic guard_n,
   output logic      sdo,
   output logic      sdo_oe,
   output logic      busy
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Reset values match the idle pin levels, so no false edge follows reset.
   logic [4:0] s1_reg, s2_reg, s3_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= 5'h13;
         s2_reg <= 5'h13;
         s3_reg <= 5'h13;
      end else if (ce) begin
         s1_reg <= {sel_n, sclk, sdi, pause_n, guard_n};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   logic cs_n, ck, di, hold_n, wg_n, ck_rise, ck_fall, cs_fall, cs_rise, wg_fall;
   assign cs_n    = s2_reg[4];
   assign ck      = s2_reg[3];
   assign di      = s2_reg[2];
   assign hold_n  = s2_reg[1];
   assign wg_n    = s2_reg[0];
   assign ck_rise = ck && !s3_reg[3];
   assign ck_fall = !ck && s3_reg[3];
   assign cs_fall = !cs_n && s3_reg[4];
   assign cs_rise = cs_n && !s3_reg[4];
   assign wg_fall = !wg_n && s3_reg[0];
   // ****************************************************************
   // Protocol state
   // ****************************************************************
   // The array is far larger than a few words, so it lives here as a plain memory.
   logic [7:0] array_mem [256];
   serial_eeprom_pkg::phase_e ph_reg, ph_next;
   serial_eeprom_pkg::byte_t  sh_reg, sh_next, tx_reg, tx_next, addr_reg, addr_next;
   serial_eeprom_pkg::byte_t  wbase_reg, wbase_next;
   logic [2:0]  bit_reg, bit_next;
   logic        armed_reg, armed_next, latch_reg, latch_next, ok_reg, ok_next;
   logic        sello_reg, sello_next, selhi_reg, selhi_next;
   logic [7:0]  pend_reg, pend_next;
   logic        wip_reg, wip_next, stw_reg, stw_next, hold_reg, hold_next;
   logic [31:0] tmr_reg, tmr_next;
   // The new protect bits wait here, because sh_reg keeps shifting on every unpaused rising clock while selected.
   logic [1:0]  stat_reg, stat_next;
   logic        sdo_next, oe_next;
   logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
   logic [8:0]  f_in_data, f_out_data;
   logic [7:0]  full_byte;
   logic [1:0]  prot;
   byte_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .flush     (f_flush),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );
   function automatic logic is_protected(input logic [1:0] p, input logic [7:0] a);
      unique case (p) // R19
         2'b00:   is_protected = 1'b0;
         2'b01:   is_protected = (a[7:6] == 2'b11);
         2'b10:   is_protected = a[7];
         default: is_protected = 1'b1;
      endcase
   endfunction
   assign full_byte = {sh_reg[6:0], di}; // R10
   assign prot      = {selhi_reg, sello_reg};
   // The array drains staged bytes only during the self-timed cycle.
   assign f_out_ready = wip_reg && !stw_reg;
   always_comb begin
      ph_next    = ph_reg;
      sh_next    = sh_reg;
      tx_next    = tx_reg;
      addr_next  = addr_reg;
      wbase_next = wbase_reg;
      bit_next   = bit_reg;
      armed_next = armed_reg;
      latch_next = latch_reg;
      ok_next    = ok_reg;
      sello_next = sello_reg;
      selhi_next = selhi_reg;
      pend_next  = pend_reg;
      wip_next   = wip_reg;
      stw_next   = stw_reg;
      tmr_next   = tmr_reg;
      hold_next  = hold_reg;
      stat_next  = stat_reg;
      sdo_next   = sdo;
      oe_next    = !cs_n && !hold_reg && armed_reg; // R3 R4
      f_in_valid = 1'b0;
      f_in_data  = 9'h000;
      f_flush    = 1'b0;
      if (cs_fall) begin
         armed_next = 1'b1; // R4
         ph_next    = serial_eeprom_pkg::PH_OPCODE;
         bit_next   = 3'd0;
         ok_next    = 1'b0;
         hold_next  = 1'b0;
         if (!wip_reg) begin
            f_flush  = 1'b1;
            stw_next = 1'b0;
         end
      end
      if (!cs_n && armed_reg && !ck && hold_reg != !hold_n) begin
         hold_next = !hold_n; // R7
      end
      if (cs_n) begin
         ph_next = serial_eeprom_pkg::PH_IDLE; // R3
      end
      if (cs_rise && ok_reg && bit_reg == 3'd0 && wg_n && !wip_reg) begin
         // R24
         wip_next  = (pend_reg != 8'h00) || stw_reg;
         tmr_next  = 32'd0;
         ok_next   = 1'b0;
      end else if (cs_rise && !wip_reg) begin
         // A cancelled status write must not block the drain of a later page write.
         f_flush  = 1'b1;
         ok_next  = 1'b0;
         stw_next = 1'b0;
      end
      if (wg_fall && !cs_n) begin
         ok_next = 1'b0; // R6
      end
      if (wip_reg) begin
         if (f_out_valid && !stw_reg) begin
            pend_next = pend_reg - 8'd1;
         end
         if (tmr_reg >= WRITE_CYCLES - 1 && !f_out_valid) begin
            wip_next   = 1'b0;
            latch_next = 1'b0; // R14
            stw_next   = 1'b0;
            pend_next  = 8'h00;
         end else begin
            tmr_next = tmr_reg + 32'd1;
         end
      end
      if (!cs_n && armed_reg && !hold_reg && ck_fall) begin
         sdo_next = tx_reg[7]; // R1
         tx_next  = {tx_reg[6:0], 1'b0};
      end
      if (!cs_n && armed_reg && !hold_reg && ck_rise &&
          ph_reg != serial_eeprom_pkg::PH_IDLE) begin
         sh_next  = full_byte; // R2 R9 R11
         bit_next = bit_reg + 3'd1;
         if (bit_reg == 3'd7) begin
            unique case (ph_reg)
               serial_eeprom_pkg::PH_OPCODE: begin
                  ph_next = serial_eeprom_pkg::PH_IGNORE;
                  unique case (full_byte) // R20 R21
                     `OP_SET_LATCH:   if (!wip_reg) latch_next = 1'b1; // R13
                     `OP_CLEAR_LATCH: if (!wip_reg) latch_next = 1'b0; // R13
                     `OP_READ_STATUS: begin
                        ph_next = serial_eeprom_pkg::PH_STATR;
                        tx_next = wip_reg ? 8'hFF : {4'h0, selhi_reg, sello_reg,
                                                     latch_reg, 1'b0}; // R15 R16 R17
                     end
                     `OP_WRITE_STATUS: begin
                        ph_next = serial_eeprom_pkg::PH_STATW;
                     end
                     `OP_READ, `OP_WRITE: ph_next = serial_eeprom_pkg::PH_ADDR; // R26
                     default: ph_next = serial_eeprom_pkg::PH_IGNORE;
                  endcase
                  stw_next = stw_reg;
                  pend_next = wip_reg ? pend_reg : 8'h00;
                  wbase_next = full_byte;
               end
               serial_eeprom_pkg::PH_ADDR: begin
                  addr_next = full_byte;
                  if (wbase_reg == `OP_READ) begin
                     ph_next = serial_eeprom_pkg::PH_RDATA;
                     tx_next = array_mem[full_byte];
                  end else begin
                     ph_next = serial_eeprom_pkg::PH_WDATA;
                  end
               end
               serial_eeprom_pkg::PH_RDATA: begin
                  addr_next = addr_reg + 8'd1; // R22
                  tx_next   = array_mem[addr_reg + 8'd1];
               end
               serial_eeprom_pkg::PH_WDATA: begin
                  // R5 R13 R27
                  if (!wip_reg && latch_reg && wg_n && !is_protected(prot, addr_reg)) begin
                     ok_next    = 1'b1;
                     f_in_valid = f_in_ready;
                     f_in_data  = {1'b0, full_byte};
                     if (f_in_ready) begin
                        pend_next = pend_reg + 8'd1;
                     end
                  end
                  addr_next = {addr_reg[7:4], addr_reg[3:0] + 4'd1}; // R23
               end
               serial_eeprom_pkg::PH_STATW: begin
                  if (!wip_reg && latch_reg && wg_n) begin
                     ok_next  = 1'b1;
                     stw_next = 1'b1;
                     stat_next = full_byte[`ST_SEL_HI_BIT:`ST_SEL_LO_BIT];
                  end
                  ph_next = serial_eeprom_pkg::PH_IGNORE;
               end
               serial_eeprom_pkg::PH_STATR: begin
                  tx_next = wip_reg ? 8'hFF : {4'h0, selhi_reg, sello_reg, latch_reg, 1'b0};
               end
               default: ;
            endcase
         end
      end
      if (wip_reg && stw_reg && tmr_reg == 32'd0) begin
         selhi_next = stat_reg[1]; // R18
         sello_next = stat_reg[0];
      end
   end
   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ph_reg    <= serial_eeprom_pkg::PH_IDLE;
         sh_reg    <= 8'h00;
         tx_reg    <= 8'h00;
         addr_reg  <= 8'h00;
         wbase_reg <= 8'h00;
         bit_reg   <= 3'd0;
         armed_reg <= 1'b0;
         latch_reg <= 1'b0; // R14
         ok_reg    <= 1'b0;
         sello_reg <= 1'b0;
         selhi_reg <= 1'b0;
         pend_reg  <= 8'h00;
         wip_reg   <= 1'b0;
         stw_reg   <= 1'b0;
         tmr_reg   <= 32'd0;
         hold_reg  <= 1'b0;
         stat_reg  <= 2'b00;
         sdo       <= 1'b0;
         sdo_oe    <= 1'b0;
         busy      <= 1'b0;
      end else if (ce) begin
         ph_reg    <= ph_next;
         sh_reg    <= sh_next;
         tx_reg    <= tx_next;
         addr_reg  <= addr_next;
         wbase_reg <= wbase_next;
         bit_reg   <= bit_next;
         armed_reg <= armed_next;
         latch_reg <= latch_next;
         ok_reg    <= ok_next;
         sello_reg <= sello_next;
         selhi_reg <= selhi_next;
         pend_reg  <= pend_next;
         wip_reg   <= wip_next;
         stw_reg   <= stw_next;
         tmr_reg   <= tmr_next;
         hold_reg  <= hold_next;
         stat_reg  <= stat_next;
         sdo       <= sdo_next;
         sdo_oe    <= oe_next;
         busy      <= wip_next;
      end
   end
   // Staged bytes carry their own address so page wrap lands where the host aimed.
   logic [7:0] waddr_mem [`FIFO_DEPTH * 2];
   logic [7:0] wa_wp_reg, wa_rp_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wa_wp_reg <= 8'h00;
         wa_rp_reg <= 8'h00;
      end else if (ce) begin
         if (f_flush) begin
            wa_wp_reg <= 8'h00;
            wa_rp_reg <= 8'h00;
         end else begin
            if (f_in_valid) wa_wp_reg <= wa_wp_reg + 8'd1;
            if (f_out_valid && f_out_ready) wa_rp_reg <= wa_rp_reg + 8'd1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (ce && f_in_valid && !f_flush) waddr_mem[wa_wp_reg[3:0]] <= addr_reg;
      if (ce && f_out_valid && f_out_ready) begin
         array_mem[waddr_mem[wa_rp_reg[3:0]]] <= f_out_data[7:0];
      end
   end
endmodule

//--- verif/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
   input  wire logic clk,
   output logic      sel_n,
   output logic      sclk,
   output logic      sdi,
   output logic      pause_n,
   output logic      guard_n,
   input  wire logic sdo
);
   // ****************************************
   // Host side of the serial link
   // ****************************************
   // Half of the 160 ns link clock, in system clocks; the link clock idles low.
   localparam int HALF = 16;
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      pause_n = 1'b1;
      guard_n = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic start();
      @(posedge clk);
      sel_n <= 1'b0;
      wait_clk(HALF);
   endtask
   // Released data line shows the inverse, so a stale bit never looks valid.
   task automatic stop();
      wait_clk(HALF);
      sel_n <= 1'b1;
      wait_clk(HALF);
      sdi <= ~sdi;
   endtask
   task automatic guard(input logic v);
      @(posedge clk);
      guard_n <= v;
   endtask
   task automatic xfer(input logic [7:0] tx, input int nb, input int ph,
                       output logic [7:0] rx);
      for (int i = 7; i > 7 - nb; i--) begin
         if (i == ph) begin
            wait_clk(HALF);
            pause_n <= 1'b0;
            wait_clk(HALF);
            sdi <= ~sdi;
            sclk <= 1'b1;
            wait_clk(HALF);
            sclk <= 1'b0;
            wait_clk(HALF);
            pause_n <= 1'b1;
            wait_clk(HALF);
         end
         sdi <= tx[i];
         wait_clk(HALF);
         sclk <= 1'b1;
         rx[i] = sdo;
         wait_clk(HALF);
         sclk <= 1'b0;
      end
   endtask
endmodule

//--- verif/serial_eeprom_sva.sv
`timescale 1ns/10ps
module serial_eeprom_sva #(
   parameter int WRITE_CYCLES = 50
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic pause_n,
   input wire logic guard_n,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic busy
);
   // ****************************************
   // Helper state and properties
   // ****************************************
   logic seen_reg;
   logic seen_next;
   logic sel_prev_reg;
   int   cnt_reg;
   int   cnt_next;
   always_comb begin
      seen_next = seen_reg | (sel_prev_reg & ~sel_n);
      cnt_next = busy ? cnt_reg + (ce ? 1 : 0) : 0;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seen_reg <= 1'b0;
         sel_prev_reg <= 1'b1;
         cnt_reg <= 0;
      end else begin
         seen_reg <= seen_next;
         sel_prev_reg <= sel_n;
         cnt_reg <= cnt_next;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_desel;
      sel_n [*6];
   endsequence
   sequence s_paused;
      !pause_n [*6];
   endsequence
   sequence s_guard_low;
      !guard_n [*8];
   endsequence
   a_release_desel: assert property (s_desel |-> !sdo_oe)
      else $error("output driven while deselected");
   a_release_pause: assert property (s_paused |-> !sdo_oe)
      else $error("output driven while paused");
   a_sdo_on_fall: assert property ($changed(sdo) && sdo_oe && $past(sdo_oe)
      |-> !sclk && !$past(sclk, 2)) else $error("output moved outside low clock");
   a_sdo_hold_high: assert property (sclk [*6] |-> $stable(sdo))
      else $error("output moved while clock high");
   a_start_on_rise: assert property ($rose(busy) |-> sel_n && $past(sel_n, 2))
      else $error("write began while selected");
   a_guard_blocks: assert property (s_guard_low |-> !$rose(busy))
      else $error("write began with guard low");
   a_busy_length: assert property ($fell(busy)
      |-> cnt_reg >= WRITE_CYCLES - 1 && cnt_reg <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   a_first_select: assert property ((sdo_oe || busy) |-> seen_reg)
      else $error("activity before first select");
endmodule
bind serial_eeprom serial_eeprom_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
   .clk(clk), .rstn(rstn), .ce(ce), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
   .pause_n(pause_n), .guard_n(guard_n), .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy));

//--- verif/serial_eeprom_tb_top.sv
`timescale 1ns/10ps
`include "serial_eeprom_params.svh"
module serial_eeprom_tb_top;
   // ****************************************
   // Bench, reference model and scenarios
   // ****************************************
   // A short write cycle keeps the run small yet outlasts one status read.
   localparam int WCYC = 2000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic sel_n, sclk, sdi, pause_n, guard_n, sdo, sdo_oe, busy;
   logic [7:0] rx;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 86277;
   int mem_m [256];
   bit vld_m [256];
   int bp_m = 0;
   int latch_m = 0;
   int a;
   int q [$];
   always #2.5 clk = ~clk;
   serial_eeprom #(.WRITE_CYCLES(WCYC)) i_dut (.clk(clk), .rstn(rstn), .ce(ce),
      .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .pause_n(pause_n), .guard_n(guard_n),
      .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy));
   // A released output shows the inverse, so reading it while undriven cannot pass.
   spi_host_model i_host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
      .pause_n(pause_n), .guard_n(guard_n), .sdo(sdo_oe ? sdo : ~sdo));
   function automatic int rb();
      return $random(seed) & 255;
   endfunction
   function automatic int prot(input int x);
      return bp_m == 3 || (bp_m == 2 && x >= 128) || (bp_m == 1 && x >= 192);
   endfunction
   task automatic chk(input string name, input int exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp[7:0]) begin
         error_cnt++;
         $display("unexpected %s: expected %0h, seen %0h", name, exp[7:0], got);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      i_host.start();
      i_host.xfer(op, 8, -1, rx);
      i_host.stop();
      latch_m = (op == `OP_SET_LATCH);
   endtask
   task automatic rd_status(input int exp);
      i_host.start();
      i_host.xfer(`OP_READ_STATUS, 8, -1, rx);
      i_host.xfer(8'h00, 8, -1, rx);
      i_host.stop();
      chk("status", exp, rx);
   endtask
   task automatic send(input logic [7:0] op, input int x, input int nb, input int gm);
      int ok;
      i_host.start();
      i_host.xfer(op, 8, -1, rx);
      if (op == `OP_WRITE) i_host.xfer(x[7:0], 8, -1, rx);
      if (gm == 1) i_host.guard(1'b0);
      foreach (q[k]) i_host.xfer(q[k][7:0], (k == q.size() - 1) ? nb : 8, -1, rx);
      if (gm == 2) i_host.guard(1'b0);
      i_host.stop();
      i_host.guard(1'b1);
      ok = latch_m && !gm && nb == 8 && !(op == `OP_WRITE && prot(x));
      i_host.wait_clk(20);
      chk("busy", ok, {7'h00, busy});
      if (ok && op == `OP_WRITE_STATUS) bp_m = (q[0] >> 2) & 3;
      else if (ok) foreach (q[k]) begin
         mem_m[(x & 240) | ((x + k) & 15)] = q[k];
         vld_m[(x & 240) | ((x + k) & 15)] = 1'b1;
      end
      if (ok) latch_m = 0;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 3 * WCYC) begin
         @(posedge clk);
         n++;
      end
      chk("busy end", 0, {7'h00, busy});
   endtask
   task automatic rd(input int x, input int n, input int ph);
      i_host.start();
      i_host.xfer(`OP_READ, 8, -1, rx);
      i_host.xfer(x[7:0], 8, -1, rx);
      for (int k = 0; k < n; k++) begin
         i_host.xfer(8'h00, 8, (k == 0) ? ph : -1, rx);
         if (vld_m[(x + k) & 255]) chk("read", mem_m[(x + k) & 255], rx);
      end
      i_host.stop();
   endtask
   task automatic wr(input int x);
      cmd(`OP_SET_LATCH);
      send(`OP_WRITE, x, 8, 0);
      wait_idle();
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd_status(8'h00);
      cmd(`OP_SET_LATCH);
      rd_status(8'h02);
      cmd(`OP_CLEAR_LATCH);
      rd_status(8'h00);
      for (int b = 0; b <= 4; b++) begin
         q = {(b & 3) * 4};
         cmd(`OP_SET_LATCH);
         send(`OP_WRITE_STATUS, 0, 8, 0);
         rd_status(8'hFF);
         @(posedge clk);
         ce <= 1'b0;
         repeat (10) @(posedge clk);
         chk("busy frozen", 1, {7'h00, busy});
         ce <= 1'b1;
         wait_idle();
         rd_status((b & 3) * 4);
         a = (rb() & 15) * 16 + 14;
         q = {rb(), rb(), rb()};
         wr(a);
         rd(a - 14, 16, -1);
      end
      q = {rb(), rb(), rb()};
      wr(254);
      q = {rb(), rb()};
      wr(0);
      q = {rb()};
      cmd(`OP_SET_LATCH);
      send(`OP_WRITE, 254, 8, 1);
      cmd(`OP_SET_LATCH);
      send(`OP_WRITE, 254, 8, 2);
      cmd(`OP_SET_LATCH);
      send(`OP_WRITE, 254, 5, 0);
      cmd(`OP_CLEAR_LATCH);
      send(`OP_WRITE, 254, 8, 0);
      rd(254, 4, 3);
      complete_run();
   end
   // Roughly 70,000 clocks of traffic are expected; this allows a wide margin.
   initial begin
      #480000;
      error_cnt++;
      complete_run();
   end
endmodule
